// ===== hdl/standby_consts.svh
/*
  Constants of the standby controller: register offsets, field positions,
  reset values, operand encodings and timing counts.
  Assumes a 20 MHz system clock; included by bare name.
*/
`ifndef STANDBY_CONSTS_SVH
`define STANDBY_CONSTS_SVH

// Register byte offsets
`define ADDR_CTRL0      5'h00
`define ADDR_CTRL1      5'h04
`define ADDR_PORT       5'h08
`define ADDR_TIMER      5'h0c
`define ADDR_HALT       5'h10
`define ADDR_STAT       5'h14

// Reset values
`define RST_CTRL0       4'h3
`define RST_CTRL1       6'h26
`define RST_PORT        4'hf

// Field positions
`define C0_DIV2         3
`define C1_SA_IN        0
`define C1_KIO_OUT      1
`define C1_SB_LED       2
`define C1_SC_REL       3
`define OP_SW_REL       3

// Operand low-bit encodings
`define OP_STOP_ALL     3'h0
`define OP_STOP_ALT     3'h3
`define OP_STOP_K0      3'h6
`define OP_HALT         3'h5

// Timing: instruction cycle is 64 clocks, wake wait in ns
`define TICK_CYC        64
`define TICK_CYC_DIV2   128
`define CLK_NS          50
`define WAIT_NS         800
`define WAIT_CYC        5'((`WAIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== hdl/standby_pkg.sv
/*
  Types shared by the standby controller.
  Assumes nothing of its surroundings.
*/
package standby_pkg;
   // Standby sequencing modes
   typedef enum logic [2:0] {
      ST_RUN,
      ST_HALT,
      ST_STOP_PEND,
      ST_STOP,
      ST_WAKE
   } mode_t;
endpackage

// ===== hdl/timer_link_if.sv
/*
  Link between the standby controller and its remote timer.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface timer_link_if;
   logic       load;
   logic [9:0] load_val;
   logic       clr;
   logic       div2;
   logic [8:0] count;
   logic       en;
   logic       zero;

   modport ctrl_side  (output load, load_val, clr, div2, input count, en, zero);
   modport timer_side (input load, load_val, clr, div2, output count, en, zero);
endinterface
`default_nettype wire

// ===== hdl/remote_timer.sv
/*
  Remote timer: 9-bit down counter with prescaler and output enable flag.
  Assumes a synchronised active-low reset from the controller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "standby_consts.svh"
module remote_timer (
   input  wire logic          ref_clk_i,
   input  wire logic          rst_n_i,
   timer_link_if.timer_side   tm
);
   typedef struct packed {
      logic [6:0] pre;
      logic [8:0] cnt;
      logic       en;
   } tstate_t;

   tstate_t q;
   tstate_t n;
   logic    tick;

   // Prescaler end, 64 or 128 clocks per step
   assign tick = q.pre == (tm.div2 ? 7'(`TICK_CYC_DIV2 - 1) : 7'(`TICK_CYC - 1));

   // Next state
   always_comb begin
      n     = q;
      n.pre = tick ? 7'h00 : q.pre + 7'h01;
      if (tm.clr) begin
         n = '0;
      end else if (tm.load) begin
         n.cnt = tm.load_val[8:0];
         n.en  = tm.load_val[9];
         n.pre = 7'h00;
      end else if (tick && q.cnt != 9'h000) begin
         n.cnt = q.cnt - 9'h001;
         if (q.cnt == 9'h001) begin
            n.en = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tm.count = q.cnt;
   assign tm.en    = q.en;
   assign tm.zero  = q.cnt == 9'h000;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_pulse_high;
      tm.load && !tm.clr && tm.load_val == 10'h200 |=> tm.en && tm.zero;
   endproperty
   a_pulse_high: assert property (p_pulse_high) else $error("pulse write not high");

   property p_count_hold;
      !tm.load && !tm.clr && !tick |=> $stable(q.cnt);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved off tick");

   property p_count_end;
      !tm.load && !tm.clr && tick && q.cnt == 9'h001 |=> tm.zero && !tm.en;
   endproperty
   a_count_end: assert property (p_count_end) else $error("timer end missed");
endmodule // remote_timer
`default_nettype wire

// ===== hdl/standby_mode_control.sv
/*
  Standby mode controller: halt operand decode, STOP/HALT sequencing,
  status flag, wake detection, remote timer output and an Avalon-MM slave.
  Assumes pins are asynchronous to ref_clk_i and that the clock may be
  gated by osc_enable_o outside this block.

  // What this block does
  // - Timer write with enable and zero count drives remote high; zero drives low.
  // - STOP stops oscillator and clamps crystal pins low.
  // - HALT stops execution; clock and timer outputs keep running.
  // - Standby keeps memory, accumulator, carry and port register unchanged.
  // - STOP entry waits for counter and output enable to be zero.
  // - Standby only via halt operand, only with status flag clear.
  // - Any standby release sets the status flag.
  // - Halt with flag set: no standby; flag follows release condition.
  // - Release condition already true: skip standby, set flag.
  // - Reset release restarts at zero; other release continues after halt.
  // - Operand 000 or 011: STOP, all key I/O high output, key wake.
  // - Operand 110: STOP, key I/O zero high output, key wake.
  // - Operand bit 3 adds enabled switch pins as wake sources.
  // - Operand x101: HALT, no precondition, released at timer zero.
  // - Illegal operand or unmet precondition raises internal reset.
  // - STOP wake waits; returns to STOP if condition gone at end.
  // - Timer steps every 64 or 128 clocks, stops at zero.
  // - Remote high while timer runs; indicator opposite.
*/
`timescale 1ns/1ps
`default_nettype none
`include "standby_consts.svh"
module standby_mode_control (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [3:0]  key_input_pins_i,
   input  wire logic        switch_input_a_i,
   input  wire logic        switch_b_or_indicator_pin_i,
   input  wire logic        switch_input_c_i,
   output logic             switch_b_or_indicator_pin_o,
   output logic             switch_b_or_indicator_pin_oe_n_o,
   output logic      [3:0]  key_io_pins_o,
   output logic             key_io_pins_oe_n_o,
   output logic             remote_output_pin_o,
   output logic             osc_enable_o,
   output logic             crystal_pins_low_o,
   output logic             cpu_halt_o,
   output logic             internal_reset_o,
   output logic             resume_next_o,
   output logic             wake_request_o
);
   typedef struct packed {
      logic [3:0]         key_s1;
      logic [3:0]         key_s2;
      logic [2:0]         sw_s1;
      logic [2:0]         sw_s2;
      logic [3:0]         ctrl0;
      logic [5:0]         ctrl1;
      logic [3:0]         port;
      logic [3:0]         op;
      logic               flag;
      standby_pkg::mode_t mode;
      logic [4:0]         wait_cnt;
      logic               ack;
      logic [31:0]        rdata;
      logic               ireset;
      logic               release_p;
   } state_t;

   state_t     q;
   state_t     n;
   logic [1:0] rst_sync_q;
   logic       rst_n;
   logic       req;
   logic       acc_wr;
   logic       wr_halt;
   logic       rel_now;
   logic [2:0] sw_raw;

   timer_link_if tm ();

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   ////////////////////////////////////////////////////////////////////////
   // Operand low bits name a STOP flavour
   function automatic logic op_is_stop(input logic [2:0] lo);
      return lo == `OP_STOP_ALL || lo == `OP_STOP_ALT || lo == `OP_STOP_K0;
   endfunction

   function automatic logic op_legal(input logic [3:0] op);
      return op_is_stop(op[2:0]) || op[2:0] == `OP_HALT;
   endfunction

   // Key I/O must already drive high in output mode
   function automatic logic precond_ok(input logic [3:0] op, input logic [5:0] c1,
                                       input logic [3:0] port);
      if (op[2:0] == `OP_HALT) begin
         return 1'b1;
      end
      if (op[2:0] == `OP_STOP_K0) begin
         return c1[`C1_KIO_OUT] & port[0];
      end
      return c1[`C1_KIO_OUT] & (&port);
   endfunction

   // Release condition selected by the operand
   function automatic logic rel_cond(input logic [3:0] op, input logic [3:0] keys,
                                     input logic [2:0] sws, input logic [5:0] c1,
                                     input logic tzero);
      logic sw_hit;
      sw_hit = (sws[0] & c1[`C1_SA_IN]) | (sws[1] & ~c1[`C1_SB_LED])
             | (sws[2] & c1[`C1_SC_REL]);
      if (op[2:0] == `OP_HALT) begin
         return tzero;
      end
      return (|keys) | (op[`OP_SW_REL] & sw_hit);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait state, write lands at the released edge
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~q.ack;
   assign acc_wr            = avs_write_i & q.ack;
   assign wr_halt           = acc_wr && avs_address_i == `ADDR_HALT && q.mode == standby_pkg::ST_RUN;
   assign sw_raw            = {switch_input_c_i, switch_b_or_indicator_pin_i, switch_input_a_i};

   assign rel_now = rel_cond(avs_writedata_i[3:0], q.key_s2, q.sw_s2, q.ctrl1, tm.zero);

   // Timer side of the link
   assign tm.load     = acc_wr && avs_address_i == `ADDR_TIMER;
   assign tm.load_val = avs_writedata_i[9:0];
   assign tm.clr      = q.ireset;
   assign tm.div2     = q.ctrl0[`C0_DIV2];

   ////////////////////////////////////////////////////////////////////////
   // Next state of the whole controller
   always_comb begin
      n           = q;
      n.key_s1    = key_input_pins_i;
      n.key_s2    = q.key_s1;
      n.sw_s1     = sw_raw;
      n.sw_s2     = q.sw_s1;
      n.ack       = req & ~q.ack;
      n.ireset    = 1'b0;
      n.release_p = 1'b0;
      if (req && !q.ack) begin
         case (avs_address_i)
            `ADDR_CTRL0: n.rdata = {28'h0, q.ctrl0};
            `ADDR_CTRL1: n.rdata = {26'h0, q.ctrl1};
            `ADDR_PORT:  n.rdata = {28'h0, q.port};
            `ADDR_TIMER: n.rdata = {22'h0, tm.en, tm.count};
            `ADDR_HALT:  n.rdata = {28'h0, q.op};
            `ADDR_STAT:  n.rdata = {27'h0, q.mode == standby_pkg::ST_WAKE,
                                    q.mode == standby_pkg::ST_STOP,
                                    q.mode == standby_pkg::ST_STOP_PEND,
                                    q.mode == standby_pkg::ST_HALT, q.flag};
            default:     n.rdata = 32'h0;
         endcase
      end
      // Settings change by bus writes and by the internal reset below
      if (acc_wr) begin
         case (avs_address_i)
            `ADDR_CTRL0: n.ctrl0 = avs_writedata_i[3:0];
            `ADDR_CTRL1: n.ctrl1 = avs_writedata_i[5:0];
            `ADDR_PORT:  n.port  = avs_writedata_i[3:0];
            `ADDR_STAT:  if (avs_writedata_i[0]) n.flag = 1'b0;
            default:     ;
         endcase
      end
      // Sequencing; any set below wins over a software clear above
      case (q.mode)
         standby_pkg::ST_RUN: begin
            if (wr_halt) begin
               n.op = avs_writedata_i[3:0];
               if (!op_legal(avs_writedata_i[3:0])) begin
                  n.ireset = 1'b1;
               end else if (q.flag) begin
                  n.flag = rel_now;
               end else if (!precond_ok(avs_writedata_i[3:0], q.ctrl1, q.port)) begin
                  n.ireset = 1'b1;
               end else if (rel_now) begin
                  n.flag = 1'b1;
               end else if (op_is_stop(avs_writedata_i[2:0])) begin
                  n.mode = (!tm.zero || tm.en) ? standby_pkg::ST_STOP_PEND
                                               : standby_pkg::ST_STOP;
               end else begin
                  n.mode = standby_pkg::ST_HALT;
               end
            end
         end
         standby_pkg::ST_HALT: begin
            if (tm.zero) begin
               n.mode      = standby_pkg::ST_RUN;
               n.flag      = 1'b1;
               n.release_p = 1'b1;
            end
         end
         standby_pkg::ST_STOP_PEND: begin
            // Enter once all timer bits clear
            if (tm.zero && !tm.en) begin
               n.mode = standby_pkg::ST_STOP;
            end
         end
         standby_pkg::ST_STOP: begin
            if (rel_cond(q.op, q.key_s2, q.sw_s2, q.ctrl1, 1'b0)) begin
               n.mode     = standby_pkg::ST_WAKE;
               n.wait_cnt = `WAIT_CYC;
            end
         end
         standby_pkg::ST_WAKE: begin
            if (q.wait_cnt != 5'h00) begin
               n.wait_cnt = q.wait_cnt - 5'h01;
            end else if (rel_cond(q.op, q.key_s2, q.sw_s2, q.ctrl1, 1'b0)) begin
               n.mode      = standby_pkg::ST_RUN;
               n.flag      = 1'b1;
               n.release_p = 1'b1;
            end else begin
               n.mode = standby_pkg::ST_STOP;
            end
         end
         default: n.mode = standby_pkg::ST_RUN;
      endcase
      if (n.ireset) begin
         n.ctrl0 = `RST_CTRL0;
         n.ctrl1 = `RST_CTRL1;
         n.port  = `RST_PORT;
         n.flag  = 1'b0;
         n.op    = 4'h0;
         n.mode  = standby_pkg::ST_RUN;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q       <= '0;
         q.ctrl0 <= `RST_CTRL0;
         q.ctrl1 <= `RST_CTRL1;
         q.port  <= `RST_PORT;
         q.mode  <= standby_pkg::ST_RUN;
      end else begin
         q <= n;
      end
   end

   remote_timer u_timer (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n),
      .tm        (tm.timer_side)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign avs_readdata_o = q.rdata;

   // Oscillator off and crystal clamp in STOP
   assign osc_enable_o       = q.mode != standby_pkg::ST_STOP;
   assign crystal_pins_low_o = q.mode == standby_pkg::ST_STOP;

   // Execution halted; timer keeps its clock
   assign cpu_halt_o = q.mode != standby_pkg::ST_RUN;

   // Reset restarts at zero, release continues
   assign internal_reset_o = q.ireset;
   assign resume_next_o    = q.release_p;

   assign remote_output_pin_o              = tm.en;
   assign switch_b_or_indicator_pin_o      = ~tm.en;
   assign switch_b_or_indicator_pin_oe_n_o = ~q.ctrl1[`C1_SB_LED];
   assign key_io_pins_o                    = q.port;
   assign key_io_pins_oe_n_o               = ~q.ctrl1[`C1_KIO_OUT];

   // Raw pins restart the oscillator, no clock needed
   assign wake_request_o = q.mode == standby_pkg::ST_STOP
                           && rel_cond(q.op, key_input_pins_i, sw_raw, q.ctrl1, 1'b0);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_halt_cmd;
      wr_halt && op_legal(avs_writedata_i[3:0]);
   endsequence

   sequence s_wake_lost;
      q.mode == standby_pkg::ST_WAKE && q.wait_cnt == 5'h00
      && !rel_cond(q.op, q.key_s2, q.sw_s2, q.ctrl1, 1'b0);
   endsequence

   property p_stop_clamp;
      q.mode == standby_pkg::ST_STOP |-> !osc_enable_o && crystal_pins_low_o;
   endproperty
   a_stop_clamp: assert property (p_stop_clamp) else $error("stop not clamped");

   property p_halt_runs;
      q.mode == standby_pkg::ST_HALT |-> cpu_halt_o && osc_enable_o;
   endproperty
   a_halt_runs: assert property (p_halt_runs) else $error("halt clock wrong");

   property p_retain;
      q.mode != standby_pkg::ST_RUN && !acc_wr && !n.ireset |=> $stable(q.port) && $stable(q.ctrl1);
   endproperty
   a_retain: assert property (p_retain) else $error("state lost in standby");

   property p_pend_hold;
      q.mode == standby_pkg::ST_STOP_PEND && !tm.zero |=> q.mode == standby_pkg::ST_STOP_PEND;
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("stop entered early");

   property p_halt_release;
      q.mode == standby_pkg::ST_HALT && tm.zero |=> q.mode == standby_pkg::ST_RUN && q.flag && resume_next_o;
   endproperty
   a_halt_release: assert property (p_halt_release) else $error("halt not released");

   property p_flag_skip;
      s_halt_cmd and q.flag && !rel_now |=> !q.flag && q.mode == standby_pkg::ST_RUN;
   endproperty
   a_flag_skip: assert property (p_flag_skip) else $error("flag not cleared");

   property p_already_rel;
      s_halt_cmd and !q.flag && rel_now && precond_ok(avs_writedata_i[3:0], q.ctrl1, q.port)
      |=> q.flag && q.mode == standby_pkg::ST_RUN;
   endproperty
   a_already_rel: assert property (p_already_rel) else $error("release not honoured");

   property p_illegal;
      wr_halt && !op_legal(avs_writedata_i[3:0]) |=> internal_reset_o ##1 !internal_reset_o;
   endproperty
   a_illegal: assert property (p_illegal) else $error("no internal reset");

   property p_wake_back;
      s_wake_lost |=> q.mode == standby_pkg::ST_STOP && !resume_next_o;
   endproperty
   a_wake_back: assert property (p_wake_back) else $error("wake not reverted");

   property p_release_flag;
      $rose(resume_next_o) |-> q.flag && q.mode == standby_pkg::ST_RUN;
   endproperty
   a_release_flag: assert property (p_release_flag) else $error("release flag clear");
endmodule // standby_mode_control
`default_nettype wire

// ===== tb/key_switch_model.sv
/*
  Far-side model: key matrix, switch pins and their pull-downs.
  Assumes the bench calls press() right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module key_switch_model (
   input  wire logic       ref_clk_i,
   input  wire logic [3:0] kio_i,
   input  wire logic       kio_oe_n_i,
   input  wire logic       sw_pull_i,
   output logic      [3:0] key_o,
   output logic      [2:0] sw_o
);
   logic [3:0] press_q = 4'h0;
   logic [2:0] swp_q   = 3'h0;
   logic       flt_q   = 1'b0;

   // Floating pattern for an unpulled switch line
   always @(posedge ref_clk_i) flt_q <= ~flt_q;

   // A pressed key only reads high through a driven high column
   assign key_o = (!kio_oe_n_i && |kio_i) ? press_q : 4'h0;
   // Without pull-down a released switch line wanders
   assign sw_o = sw_pull_i ? swp_q : (swp_q | {3{flt_q}});

   // Hold keys and switches for a number of cycles, then release
   task automatic press(input logic [3:0] k, input logic [2:0] s, input int cyc);
      @(posedge ref_clk_i);
      press_q <= k;
      swp_q <= s;
      repeat (cyc) @(posedge ref_clk_i);
      press_q <= 4'h0;
      swp_q <= 3'h0;
   endtask
endmodule // key_switch_model
`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench of the standby controller.
  Assumes design files and the pin model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "standby_consts.svh"
module testbench;
   typedef struct packed {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e; logic r;} row_t;
   logic        ref_clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, sw_pull = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        wreq, sb_o, sb_oe_n, kio_oe_n, remote_output_pin, osc, xlow, halt, irst, rnext, wake;
   logic [3:0]  key, kio;
   logic [2:0]  sw;
   int          n_mismatch = 0, checks = 0, n_rst = 0, n_res = 0, n;
   logic [3:0]  ops [4] = '{4'h0, 4'h3, 4'h6, 4'h8};
   logic [15:0] bad [7] = '{16'h24f0, 16'h26e6, 16'h26f1, 16'h26f2, 16'h26f4, 16'h26f7, 16'h26f9};
   row_t rows [10] = '{
      '{1'b0, 5'h00, 32'h0, 32'h3, 1'b0}, '{1'b0, 5'h04, 32'h0, 32'h26, 1'b0},
      '{1'b0, 5'h08, 32'h0, 32'hf, 1'b0}, '{1'b0, 5'h0c, 32'h0, 32'h0, 1'b0},
      '{1'b0, 5'h14, 32'h0, 32'h0, 1'b0}, '{1'b1, 5'h18, 32'hff, 32'h0, 1'b0},
      '{1'b0, 5'h18, 32'h0, 32'h0, 1'b0}, '{1'b1, 5'h0c, 32'h200, 32'h0, 1'b1},
      '{1'b0, 5'h0c, 32'h0, 32'h200, 1'b1}, '{1'b1, 5'h0c, 32'h0, 32'h0, 1'b0}};

   standby_mode_control u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .key_input_pins_i(key), .switch_input_a_i(sw[0]),
      .switch_b_or_indicator_pin_i(sb_oe_n ? sw[1] : sb_o), .switch_input_c_i(sw[2]),
      .switch_b_or_indicator_pin_o(sb_o), .switch_b_or_indicator_pin_oe_n_o(sb_oe_n),
      .key_io_pins_o(kio), .key_io_pins_oe_n_o(kio_oe_n), .remote_output_pin_o(remote_output_pin),
      .osc_enable_o(osc), .crystal_pins_low_o(xlow), .cpu_halt_o(halt),
      .internal_reset_o(irst), .resume_next_o(rnext), .wake_request_o(wake));
   key_switch_model u_pins (.ref_clk_i(ref_clk), .kio_i(kio), .kio_oe_n_i(kio_oe_n),
      .sw_pull_i(sw_pull), .key_o(key), .sw_o(sw));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and counters of the one-cycle pulses
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (irst === 1'b1) n_rst <= n_rst + 1;
      if (rnext === 1'b1) n_res <= n_res + 1;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Avalon cycle; request held until waitrequest is sampled low at a rising edge,
   // read data taken and request dropped at that very edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wdat <= d;
      do begin
         @(posedge ref_clk);
         k++;
      end while (wreq !== 1'b0 && k < 20);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 20) chk(k, 0);
   endtask

   // Wait, bounded, for one release pulse; n gives the cycles taken
   task automatic wait_res(input int lim);
      int k0;
      k0 = n_res;
      n = 0;
      while (n_res == k0 && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      chk(n_res - k0, 1);
   endtask

   task automatic complete_run;
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog, well beyond the under two thousand cycles of the run
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(q, rows[i].e);
         @(negedge ref_clk);
         chk(remote_output_pin, rows[i].r);
      end
      // Timed halt, released by the timer reaching zero
      bus(1'b1, 5'h0c, 32'h203);
      bus(1'b1, 5'h10, 32'h5);
      @(negedge ref_clk);
      chk({halt, osc, remote_output_pin, sb_o}, 4'b1110);
      wait_res(400);
      chk(n > 2 * `TICK_CYC && n <= 3 * `TICK_CYC + 4, 1);
      @(negedge ref_clk);
      chk({halt, kio}, 5'h0f);
      bus(1'b0, 5'h14, 32'h0);
      chk(q[0], 1'b1);
      // Flag set, timer busy: no standby, flag drops
      bus(1'b1, 5'h0c, 32'h5);
      bus(1'b1, 5'h10, 32'h5);
      bus(1'b0, 5'h14, 32'h0);
      chk({halt, q[0]}, 2'b00);
      repeat (7 * `TICK_CYC) @(posedge ref_clk);
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, 5'h10, 32'h5);
         bus(1'b0, 5'h14, 32'h0);
         chk({halt, q[0]}, 2'b01);
      end
      // STOP asked while the timer still counts
      bus(1'b1, 5'h14, 32'h1);
      bus(1'b1, 5'h0c, 32'h2);
      bus(1'b1, 5'h10, 32'h0);
      @(negedge ref_clk);
      chk({halt, osc, xlow}, 3'b110);
      n = 0;
      while (xlow !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      chk({n >= `TICK_CYC, osc, xlow}, 3'b101);
      // Raw wake request follows the pin before the synchronised wake
      fork
         u_pins.press(4'h1, 3'h0, 40);
         wait_res(80);
         begin
            @(negedge ref_clk);
            chk(wake, 1'b0);
            @(negedge ref_clk);
            chk(wake, 1'b1);
         end
      join
      // Every STOP encoding: a short blip falls back, a held press wakes
      foreach (ops[i]) begin
         if (ops[i][3]) begin
            sw_pull <= 1'b1;
            bus(1'b1, 5'h04, 32'h33);
         end
         bus(1'b1, 5'h14, 32'h1);
         bus(1'b1, 5'h10, {28'h0, ops[i]});
         @(negedge ref_clk);
         chk({halt, osc, xlow}, 3'b101);
         n = n_res;
         u_pins.press(4'hf, 3'h0, 2);
         repeat (40) @(posedge ref_clk);
         chk({n_res == n, xlow}, 2'b11);
         fork
            u_pins.press(ops[i][3] ? 4'h0 : 4'(1 << i), {2'b00, ops[i][3]}, 40);
            wait_res(80);
         join
      end
      // Bad operands and unmet preconditions restart the core
      foreach (bad[i]) begin
         bus(1'b1, 5'h04, {24'h0, bad[i][15:8]});
         bus(1'b1, 5'h08, {28'h0, bad[i][7:4]});
         bus(1'b1, 5'h14, 32'h1);
         n = n_rst;
         bus(1'b1, 5'h10, {28'h0, bad[i][3:0]});
         repeat (3) @(posedge ref_clk);
         chk(n_rst - n, 1);
         bus(1'b0, 5'h04, 32'h0);
         chk(q, 32'h26);
      end
      // Halved timer clock: one step of the HALT wait takes 128 clocks
      bus(1'b1, 5'h00, 32'h8);
      bus(1'b1, 5'h0c, 32'h1);
      bus(1'b1, 5'h10, 32'h5);
      wait_res(400);
      chk(n > `TICK_CYC && n <= `TICK_CYC_DIV2 + 4, 1);
      // Mid-run reset: pins and registers fall back to their reset values
      bus(1'b1, 5'h08, 32'h0);
      bus(1'b1, 5'h04, 32'h0);
      rst_n <= 1'b0;
      @(negedge ref_clk);
      chk({kio, kio_oe_n, sb_oe_n, sb_o, remote_output_pin, osc, halt}, {4'hf, 6'b001010});
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bus(1'b0, 5'h08, 32'h0);
      chk(q, 32'hf);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
